// File: design/acs_pkg.sv
// Package for the conversion sequencer: register map, field layout, timing counts.
// Assumes a 32-bit AHB-Lite register bus and one 40 MHz clock.
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] ACS_OFF_CTRL_A = 8'h00;  // converter_control_status_a
  localparam logic [7:0] ACS_OFF_CTRL_B = 8'h04;  // converter_control_status_b
  localparam logic [7:0] ACS_OFF_CHAN   = 8'h08;  // channel select
  localparam logic [7:0] ACS_OFF_RES_LO = 8'h0C;  // result_low_byte
  localparam logic [7:0] ACS_OFF_RES_HI = 8'h10;  // result_high_byte
  localparam logic [7:0] ACS_OFF_STAT   = 8'h14;  // live status
  // Control A fields
  localparam int ACS_A_DIV_LSB = 0;   // clock_divider_select, 3 bits
  localparam int ACS_A_DONE    = 4;   // conversion_done_flag, write one to clear
  localparam int ACS_A_ATE     = 5;   // auto_trigger_enable
  localparam int ACS_A_START   = 6;   // conversion_start_bit
  localparam int ACS_A_EN      = 7;   // converter_enable
  // Control B fields
  localparam int ACS_B_TS_LSB  = 0;   // trigger_source_select, 3 bits
  localparam int ACS_B_DIFF    = 4;   // differential channel mode
  localparam int ACS_B_HSM     = 7;   // high_speed_mode_bit
  // Trigger source code that selects the done flag (free running)
  localparam logic [2:0] ACS_TS_FREE = 3'h0;
  // Conversion lengths and sample-hold instants in converter clock cycles, half-cycle resolution
  localparam logic [5:0] ACS_NORM_HALVES  = 6'h1A;  // 13 cycles
  localparam logic [5:0] ACS_FIRST_HALVES = 6'h32;  // 25 cycles
  localparam logic [5:0] ACS_AUTO_HALVES  = 6'h1B;  // 13.5 cycles
  localparam logic [5:0] ACS_DIFF_HALVES  = 6'h1C;  // 14 cycles
  localparam logic [5:0] ACS_SH_NORM      = 6'h03;  // 1.5 cycles
  localparam logic [5:0] ACS_SH_FIRST     = 6'h1B;  // 13.5 cycles
  localparam logic [5:0] ACS_SH_AUTO      = 6'h04;  // 2 cycles
  localparam logic [1:0] HTRANS_NONSEQ    = 2'b10;
endpackage

// File: design/acs_sequencer.sv
// Conversion sequencer: prescaler, start logic, phase counting, result capture.
// Assumes an AHB-Lite master, trigger pins from other clock domains and an
// analog successive-approximation array that presents its result on sar_result.
// Operation
// [R1] Start bit begins one conversion, self-clears
// [R2] Channel change waits until conversion ends
// [R3] Selected trigger rising edge restarts prescaler, converts
// [R4] Held trigger or mid-conversion edge ignored
// [R5] Flags set regardless; software clears trigger flag
// [R6] Done flag as source gives free running
// [R7] Start bit works with auto-trigger; reads busy
// [R8] Divider select sets prescaler; enable gates it
// [R9] Software start begins on next converter edge
// [R10] Normal 13 cycles, first 25 cycles
// [R11] Sample-hold at 1.5 or 13.5 cycles
// [R12] Completion writes result, sets done, clears start
// [R13] Auto trigger: sample at 2, length 13.5
// [R14] Free running restarts immediately, start stays high
// [R15] Differential aligns to half-rate clock, 13/14
// [R16] Free-running differential restarts take 14
// [R17] Software toggles enable between differential triggers
// [R18] Software keeps converter clock 50-200 kHz
// [R19] High speed bit allows faster converter clock
// [R20] Low byte read locks result until high read
// [R21] Selections take effect only while enabled
// [R22] Trigger edge found by registered compare
`timescale 1ns/10ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int NTRIG = 8
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [NTRIG-1:1] trigger_in,
  input  wire logic [9:0]       sar_result,
  output logic                  sample_hold,
  output logic                  sar_active,
  output logic      [4:0]       sar_channel,
  output logic                  high_speed_mode
);
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_WAIT = 3'b010,
    ACS_CONV = 3'b100
  } acs_state_t;

  acs_state_t  state;
  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  logic [4:0]  chan_buf;
  logic [9:0]  result;
  logic        lock;
  logic        first_pending;
  logic [6:0]  pre_cnt;
  logic        half_clk;
  logic        half_tick;
  logic [5:0]  phase;
  logic [5:0]  conv_len;
  logic [5:0]  sh_at;
  logic [NTRIG-1:1] trig_s1;
  logic [NTRIG-1:1] trig_s2;
  logic        trig_prev;
  logic        sync_clk2;
  logic        wr_pend;
  logic [7:0]  a_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Derived terms
  wire enabled   = ctrl_a[ACS_A_EN];
  wire [2:0] tsel = ctrl_b[ACS_B_TS_LSB +: 3];
  wire free_run  = ctrl_a[ACS_A_ATE] && tsel == ACS_TS_FREE;
  // Source 0 is the done flag itself; others are synchronised pins
  wire trig_sel  = (tsel == ACS_TS_FREE) ? ctrl_a[ACS_A_DONE] : trig_s2[tsel];
  wire trig_edge = ctrl_a[ACS_A_ATE] && !free_run && trig_sel && !trig_prev; // see [R22]
  wire busy      = state != ACS_IDLE;
  wire done_now  = state == ACS_CONV && half_tick && phase == conv_len - 6'd1;
  wire take      = hsel && hready && htrans == HTRANS_NONSEQ;

  // Divider as half-period count: 2^(sel) cycles, sel 0 behaves as 2
  function automatic logic [6:0] half_period(input logic [2:0] sel);
    return (sel == 3'h0) ? 7'h01 : 7'(7'h01 << (sel - 3'h1));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchronisers and previous selected level; held high means no edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_s1   <= '0;
      trig_s2   <= '0;
      trig_prev <= 1'b0;
    end
    else
    begin
      trig_s1   <= trigger_in;
      trig_s2   <= trig_s1;
      trig_prev <= trig_sel;  // see [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: produces a half-period tick; reset while disabled or on trigger
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_cnt   <= '0;
      half_clk  <= 1'b0;
      half_tick <= 1'b0;
    end
    else if (!enabled || (trig_edge && !busy))  // see [R8] see [R3] see [R13]
    begin
      pre_cnt   <= '0;
      half_clk  <= 1'b0;
      half_tick <= 1'b0;
    end
    else if (pre_cnt == half_period(ctrl_a[ACS_A_DIV_LSB +: 3]) - 7'd1)
    begin
      pre_cnt   <= '0;
      half_clk  <= ~half_clk;
      half_tick <= 1'b1;  // see [R8]
    end
    else
    begin
      pre_cnt   <= pre_cnt + 7'd1;
      half_tick <= 1'b0;
    end
  end

  // Half-rate sync clock toggles on each falling converter edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_clk2 <= 1'b0;
    else if (!enabled)
      sync_clk2 <= 1'b0;
    else if (half_tick && !half_clk)
      sync_clk2 <= ~sync_clk2;  // see [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and phase counter (in converter half-cycles)
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state        <= ACS_IDLE;
      phase        <= '0;
      conv_len     <= ACS_NORM_HALVES;
      sh_at         <= ACS_SH_NORM;
      first_pending <= 1'b1;
    end
    else if (!enabled)
    begin
      state         <= ACS_IDLE;
      first_pending <= 1'b1;  // see [R10]
    end
    else
    begin
      case (state)
        ACS_IDLE:
          if (trig_edge)  // see [R3]
          begin
            state        <= ACS_CONV;
            phase        <= '0;
            conv_len     <= first_pending ? ACS_FIRST_HALVES : ACS_AUTO_HALVES;  // see [R13]
            sh_at        <= first_pending ? ACS_SH_FIRST : ACS_SH_AUTO;
          end
          else if (ctrl_a[ACS_A_START])  // see [R1] see [R7]
            state <= ACS_WAIT;
        ACS_WAIT:
          if (half_tick && !half_clk)  // see [R9]
          begin
            state        <= ACS_CONV;
            phase        <= '0;
            sh_at        <= first_pending ? ACS_SH_FIRST : ACS_SH_NORM;  // see [R11]
            if (first_pending)
              conv_len <= ACS_FIRST_HALVES;  // see [R10]
            else if (ctrl_b[ACS_B_DIFF] && sync_clk2)
              conv_len <= ACS_DIFF_HALVES;  // see [R15]
            else
              conv_len <= ACS_NORM_HALVES;
          end
        ACS_CONV:
          if (done_now)
          begin
            phase         <= '0;
            first_pending <= 1'b0;  // see [R10]
            if (free_run)  // see [R6] see [R14]
            begin
              state    <= ACS_CONV;
              sh_at    <= ACS_SH_NORM;
              conv_len <= ctrl_b[ACS_B_DIFF] ? ACS_DIFF_HALVES : ACS_NORM_HALVES;  // see [R16]
            end
            else
              state <= ACS_IDLE;
          end
          else if (half_tick)
            phase <= phase + 6'd1;
        default:
          state <= ACS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog-side outputs; channel held steady during a conversion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sample_hold     <= 1'b0;
      sar_active      <= 1'b0;
      sar_channel     <= '0;
      high_speed_mode <= 1'b0;
    end
    else
    begin
      sample_hold     <= state == ACS_CONV && half_tick && phase == sh_at - 6'd1;  // see [R11]
      sar_active      <= state == ACS_CONV;
      high_speed_mode <= ctrl_b[ACS_B_HSM];  // see [R19]
      if (enabled && (state != ACS_CONV || done_now))
        sar_channel <= chan_buf;  // see [R2] see [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      a_addr  <= '0;
    end
    else
    begin
      wr_pend <= take && hwrite;
      if (take)
        a_addr <= haddr[7:0];
    end
  end

  // Control registers; hardware set of done beats a software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_a   <= '0;
      ctrl_b   <= '0;
      chan_buf <= '0;
    end
    else
    begin
      // Hardware start first, so a start written together with enable survives
      if (!enabled)
        ctrl_a[ACS_A_START] <= 1'b0;
      else if (trig_edge && !busy)
        ctrl_a[ACS_A_START] <= 1'b1;  // see [R7]
      else if (done_now && !free_run)
        ctrl_a[ACS_A_START] <= 1'b0;  // see [R12]
      if (wr_pend && a_addr == ACS_OFF_CTRL_A)
      begin
        ctrl_a[ACS_A_DIV_LSB +: 3] <= hwdata[ACS_A_DIV_LSB +: 3];
        ctrl_a[ACS_A_ATE]          <= hwdata[ACS_A_ATE];
        ctrl_a[ACS_A_EN]           <= hwdata[ACS_A_EN];
        if (hwdata[ACS_A_START] && hwdata[ACS_A_EN])
          ctrl_a[ACS_A_START] <= 1'b1;  // see [R1]
        if (hwdata[ACS_A_DONE])
          ctrl_a[ACS_A_DONE] <= 1'b0;  // see [R5]
      end
      if (wr_pend && a_addr == ACS_OFF_CTRL_B)
        ctrl_b <= hwdata[7:0];
      if (wr_pend && a_addr == ACS_OFF_CHAN)
        chan_buf <= hwdata[4:0];
      if (done_now)
        ctrl_a[ACS_A_DONE] <= 1'b1;  // see [R5] see [R12]
    end
  end

  // Result capture with low-then-high read lock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result <= '0;
      lock   <= 1'b0;
    end
    else
    begin
      if (done_now && !lock)
        result <= sar_result;  // see [R12] see [R20]
      if (take && !hwrite && haddr[7:0] == ACS_OFF_RES_LO)
        lock <= 1'b1;  // see [R20]
      else if (take && !hwrite && haddr[7:0] == ACS_OFF_RES_HI)
        lock <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and response; zero wait states, always OKAY
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (take && !hwrite)
    begin
      case (haddr[7:0])
        ACS_OFF_CTRL_A: hrdata <= {24'h00_0000, ctrl_a};
        ACS_OFF_CTRL_B: hrdata <= {24'h00_0000, ctrl_b};
        ACS_OFF_CHAN:   hrdata <= {27'h000_0000, chan_buf};
        ACS_OFF_RES_LO: hrdata <= {24'h00_0000, result[7:0]};
        ACS_OFF_RES_HI: hrdata <= {30'h0000_0000, result[9:8]};
        ACS_OFF_STAT:   hrdata <= {26'h000_0000, lock, first_pending, sync_clk2, state};
        default:        hrdata <= '0;
      endcase
    end
  end
endmodule

// File: sim/acs_sequencer_props.sv
// Checker on sequencer ports: bus answers, sample pulse, channel lock.
// Assumes it is bound to acs_sequencer and sees only its ports.
`timescale 1ns/10ps
module acs_props
  import acs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sample_hold,
  input wire logic        sar_active,
  input wire logic [4:0]  sar_channel,
  input wire logic        high_speed_mode
);
  logic take;
  logic rd_q;
  logic um_q;
  logic wb_q;
  logic hsm_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Address phase accepted at this edge
  assign take = hsel && hready && htrans == HTRANS_NONSEQ;
  // Data-phase markers, so read data is judged one edge after its address
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rd_q  <= 1'b0;
      um_q  <= 1'b0;
      wb_q  <= 1'b0;
      hsm_d <= 1'b0;
    end
    else
    begin
      rd_q <= take && !hwrite;
      um_q <= take && !hwrite && haddr[7:0] > ACS_OFF_STAT;
      wb_q <= take && hwrite && haddr[7:0] == ACS_OFF_CTRL_B;
      if (wb_q)
        hsm_d <= hwdata[ACS_B_HSM];
    end
  ////////////////////////////////////////////////////////////////////////
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_unmapped;
    um_q |-> hrdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !rd_q |-> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_sh_pulse;
    sample_hold |=> !sample_hold;
  endproperty
  a_sh_pulse: assert property (p_sh_pulse) else $error("sample pulse too long");
  property p_sh_active;
    sample_hold |-> sar_active;
  endproperty
  a_sh_active: assert property (p_sh_active) else $error("sample outside conversion");
  // The channel may legally move on the done edge, so judge only the opening cycles
  property p_chan;
    $rose(sar_active) |-> $stable(sar_channel) [*8];
  endproperty
  a_chan: assert property (p_chan) else $error("channel moved mid conversion");
  property p_hsm;
    wb_q |=> ##[0:1] high_speed_mode == hsm_d;
  endproperty
  a_hsm: assert property (p_hsm) else $error("high speed copy wrong");
endmodule
bind acs_sequencer acs_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sample_hold(sample_hold),
  .sar_active(sar_active), .sar_channel(sar_channel), .high_speed_mode(high_speed_mode));

// File: sim/acs_sequencer_tb_top.sv
// Testbench: register-bus sequences driving the sequencer, with timing monitors.
// Assumes divider 1, so one converter cycle is two clocks.
`timescale 1ns/10ps
module acs_sequencer_tb_top
  import acs_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic [7:1]  trigger_in = 7'h00;
  logic [9:0]  sar_result = 10'h2A5;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [4:0]  sar_channel;
  logic        hreadyout, hresp, sample_hold, sar_active, high_speed_mode;
  wire         hready = hreadyout;
  int errors = 0, comparisons = 0, run_len = 0, last_len = 0, ndone = 0;
  int sh_off = 0, sh_gap = 0, sh_at = 0, cyc = 0;
  acs_sequencer DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in), .sar_result(sar_result),
    .sample_hold(sample_hold), .sar_active(sar_active), .sar_channel(sar_channel),
    .high_speed_mode(high_speed_mode));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Lengths in clocks; free running may keep sar_active high, so gaps too.
  // sar_active rises two clocks after the converter edge of a software start
  // but one clock after the trigger edge of an auto start, and sample_hold
  // lags its instant by one clock: software starts read offset halves-1 and
  // length halves, auto starts offset halves and length halves+1.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (sample_hold)
    begin
      sh_off <= run_len;
      sh_gap <= cyc - sh_at;
      sh_at <= cyc;
    end
    if (sar_active)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      ndone <= ndone + 1;
      run_len <= 0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for one condition kind: 0 ready, 1 active, 2 done
  task automatic await(input int kind, input int lim);
    int n0, k;
    n0 = ndone;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!(kind == 0 ? hreadyout === 1'b1 : kind == 1 ? sar_active === 1'b1
             : ndone != n0) && k < lim);
    if (k >= lim)
    begin
      errors++;
      wrap_up();
    end
  endtask
  // One single word transfer; read data lands in q
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    await(0, 20);
    htrans <= 2'b00;
    hwdata <= d;
    await(0, 20);
    q = hrdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      bus(i == 5 ? 8'h18 : 8'(i * 4), 1'b0, 32'h0000_0000);
      check(q, 32'h0000_0000);
    end
    bus(ACS_OFF_CHAN, 1'b1, 32'h0000_0003);
    check(sar_channel, 5'h00);
    // Divider 1 runs far above the full-resolution band; only timing is judged
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00C1);
    bus(ACS_OFF_CTRL_A, 1'b0, 32'h0000_0000);
    check(q[ACS_A_START], 1'b1);
    check(sar_channel, 5'h03);
    await(2, 3000);
    check(last_len, 50);
    check(sh_off, 26);
    bus(ACS_OFF_CTRL_A, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_0091);
    bus(ACS_OFF_RES_LO, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_00A5);
    bus(ACS_OFF_RES_HI, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_0002);
    $display("test first conversion done");
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00C1);
    await(1, 100);
    bus(ACS_OFF_CHAN, 1'b1, 32'h0000_0005);
    check(sar_channel, 5'h03);
    await(2, 3000);
    check(last_len, 26);
    check(sh_off, 2);
    check(sar_channel, 5'h05);
    sar_result <= 10'h1C3;
    bus(ACS_OFF_RES_LO, 1'b0, 32'h0000_0000);
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00D1);
    await(2, 3000);
    bus(ACS_OFF_CTRL_A, 1'b0, 32'h0000_0000);
    check(q[ACS_A_DONE], 1'b1);
    bus(ACS_OFF_RES_HI, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_0002);
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00D1);
    await(2, 3000);
    bus(ACS_OFF_RES_LO, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_00C3);
    $display("test normal conversion done");
    bus(ACS_OFF_CTRL_B, 1'b1, 32'h0000_0001);
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00B1);
    n0 = ndone;
    trigger_in[1] <= 1'b1;
    await(1, 100);
    trigger_in[1] <= 1'b0;
    await(0, 20);
    trigger_in[1] <= 1'b1;
    await(2, 3000);
    check(last_len, 28);
    check(sh_off, 4);
    repeat (100) @(posedge clk);
    check(ndone - n0, 1);
    trigger_in[1] <= 1'b0;
    $display("test auto trigger done");
    bus(ACS_OFF_CTRL_B, 1'b1, 32'h0000_0090);
    repeat (2) @(posedge clk);
    check(high_speed_mode, 1'b1);
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00F1);
    repeat (200) @(posedge clk);
    check(sh_gap, 28);
    bus(ACS_OFF_CTRL_B, 1'b1, 32'h0000_0000);
    repeat (200) @(posedge clk);
    check(sh_gap, 26);
    bus(ACS_OFF_CTRL_A, 1'b0, 32'h0000_0000);
    check(q[ACS_A_START], 1'b1);
    bus(ACS_OFF_CTRL_B, 1'b1, 32'h0000_0011);
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_0041);
    repeat (100) @(posedge clk);
    check(sar_active, 1'b0);
    // Differential auto trigger only after a disable and re-enable
    bus(ACS_OFF_CTRL_A, 1'b1, 32'h0000_00A1);
    trigger_in[1] <= 1'b1;
    await(2, 3000);
    check(last_len, 51);
    $display("test free running and enable done");
    wrap_up();
  end
endmodule
